// file: rtl/sslk_pkg.sv
// Purpose: shared constants for the subroutine stack linkage block
// Assumes: 16-bit words, byte addressed memory, eight general registers
// Notes: no software-visible registers
package sslk_pkg;
	localparam int unsigned DATA_W = 16;
	localparam int unsigned REG_IDX_W = 3;
	localparam logic [2:0] SP_IDX = 3'h6;
	localparam logic [2:0] PC_IDX = 3'h7;
	localparam logic [15:0] WORD_STEP = 16'h0002;
	localparam logic [15:0] BYTE_STEP = 16'h0001;
	localparam logic [15:0] RESET_SP = 16'h0000;
	localparam logic [15:0] RESET_PC = 16'h0000;
	localparam logic [15:0] RESET_PSW = 16'h0000;
	localparam logic [15:0] WORD_ALIGN_MASK = 16'hFFFE;
endpackage

// file: rtl/sslk_mem_if.sv
// Purpose: word access path from the linkage sequencer to the stack memory port
// Assumes: one request held until acknowledged
// Notes: carries the memory handshake between the two modules
`timescale 1ns/100ps
`default_nettype none
interface sslk_mem_if;
	logic req;
	logic we;
	logic [15:0] addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic ack;
	logic err;
	modport seq (output req, output we, output addr, output wdata,
		input rdata, input ack, input err);
	modport port (input req, input we, input addr, input wdata,
		output rdata, output ack, output err);
endinterface
`default_nettype wire

// file: rtl/sslk_mem_port.sv
// Purpose: drives the external stack memory pins from the sequencer request
// Assumes: memory answers with ack or err, one cycle pulse, any latency
// Notes: address is forced word aligned on the way out
`timescale 1ns/100ps
`default_nettype none
module sslk_mem_port (
	// sequencer side
	sslk_mem_if.port mem,
	// memory pins
	output logic mem_req_o,
	output logic mem_we_o,
	output logic [15:0] mem_addr_o,
	output logic [15:0] mem_wdata_o,
	input wire logic [15:0] mem_rdata_i,
	input wire logic mem_ack_i,
	input wire logic mem_err_i
);
	// pass-through with word alignment of the stack address
	assign mem_req_o = mem.req;
	assign mem_we_o = mem.we;
	assign mem_addr_o = mem.addr & sslk_pkg::WORD_ALIGN_MASK; // [R06]
	assign mem_wdata_o = mem.wdata;
	assign mem.rdata = mem_rdata_i;
	assign mem.ack = mem_ack_i;
	assign mem.err = mem_err_i;
endmodule
`default_nettype wire

// file: rtl/sslk_top.sv
// Purpose: call, return and trap linkage through the hardware stack
// Assumes: one operation at a time, memory holds stack words
// Notes: register file of eight words; register six is the stack pointer
//
// What this block does
// [R01] call first pushes the linkage register with predecrement through the stack pointer
// [R02] then linkage register takes the return address and pc takes the entry
// [R03] pc as linkage pushes return address, then pc takes the entry address
// [R04] return moves named register to pc, then pops top word into it
// [R05] trap or interrupt entry pushes pc and status word onto the stack
// [R06] hardware stack pointer addresses whole words only, never odd bytes
// [R07] autoincrement steps one per byte item, two per word item
// [R08] stacks grow downward; pointer holds address of last stored item
// [R09] register six is the implicit stack pointer; any but seven may serve
// [R10] stack write completes before linkage register and pc update
`timescale 1ns/100ps
`default_nettype none
module sslk_top (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// operation request
	input wire logic call_i,
	input wire logic ret_i,
	input wire logic trap_i,
	input wire logic pop_i,
	input wire logic pop_byte_i,
	input wire logic [2:0] link_reg_i,
	input wire logic [2:0] pop_reg_i,
	input wire logic [15:0] target_i,
	input wire logic [15:0] ret_addr_i,
	input wire logic [15:0] psw_in_i,
	output logic busy_o,
	output logic done_o,
	output logic fault_o,
	// architectural state
	output logic [15:0] pc_o,
	output logic [15:0] sp_o,
	output logic [15:0] psw_o,
	input wire logic [2:0] rd_idx_i,
	output logic [15:0] rd_data_o,
	// memory pins
	output logic mem_req_o,
	output logic mem_we_o,
	output logic [15:0] mem_addr_o,
	output logic [15:0] mem_wdata_o,
	input wire logic [15:0] mem_rdata_i,
	input wire logic mem_ack_i,
	input wire logic mem_err_i
);
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_PUSH1 = 6'h02,
		ST_PUSH2 = 6'h04,
		ST_POP = 6'h08,
		ST_DONE = 6'h10,
		ST_FAULT = 6'h20
	} sslk_state_e;
	typedef enum logic [1:0] {
		OP_CALL = 2'h0,
		OP_RET = 2'h1,
		OP_TRAP = 2'h2,
		OP_POP = 2'h3
	} sslk_op_e;

	sslk_mem_if mem ();

	logic [15:0] regs_q [8];
	sslk_state_e state_q;
	sslk_op_e op_q;
	logic [2:0] idx_q;
	logic [15:0] tgt_q;
	logic [15:0] ra_q;
	logic [15:0] psw_save_q;
	logic [15:0] psw_q;
	logic byte_q;
	logic done_q;
	logic fault_q;

	// word-aligned predecrement of a stack pointer
	function automatic logic [15:0] sslk_push_addr(input logic [15:0] sp);
		sslk_push_addr = (sp - sslk_pkg::WORD_STEP) & sslk_pkg::WORD_ALIGN_MASK;
	endfunction

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	wire logic [15:0] sp_cur = regs_q[sslk_pkg::SP_IDX]; // [R09]
	wire logic [15:0] sp_dec = sslk_push_addr(sp_cur); // [R08]
	wire logic [15:0] pop_ptr = regs_q[idx_q];
	wire logic [15:0] step = byte_q ? sslk_pkg::BYTE_STEP : sslk_pkg::WORD_STEP; // [R07]
	wire logic pop_on_sp = (op_q == OP_RET) || (idx_q == sslk_pkg::SP_IDX);
	// byte stepping only applies to a pop; a stale flag must not trip a return
	wire logic byte_ok = !(op_q == OP_POP && byte_q && idx_q == sslk_pkg::SP_IDX); // [R06]
	wire logic pop_bad = (pop_reg_i == sslk_pkg::PC_IDX); // [R09]
	wire logic pop_odd_sp = pop_byte_i && (pop_reg_i == sslk_pkg::SP_IDX); // [R06]
	wire logic [15:0] pc_word = (op_q == OP_CALL && idx_q != sslk_pkg::PC_IDX)
		? regs_q[idx_q] : ra_q; // [R03]
	wire logic in_push = (state_q == ST_PUSH1) || (state_q == ST_PUSH2);
	wire logic in_pop = (state_q == ST_POP);
	wire logic [15:0] pop_addr = pop_on_sp ? sp_cur : pop_ptr;
	wire logic [15:0] pop_next = pop_on_sp ? sp_cur + sslk_pkg::WORD_STEP : pop_ptr + step;

	// memory request built from the current state
	assign mem.req = in_push || in_pop;
	assign mem.we = in_push;
	assign mem.addr = in_push ? sp_dec : pop_addr;
	assign mem.wdata = (state_q == ST_PUSH2) ? psw_save_q : pc_word; // [R01] [R05]

	sslk_mem_port u_port (
		.mem(mem.port),
		.mem_req_o(mem_req_o),
		.mem_we_o(mem_we_o),
		.mem_addr_o(mem_addr_o),
		.mem_wdata_o(mem_wdata_o),
		.mem_rdata_i(mem_rdata_i),
		.mem_ack_i(mem_ack_i),
		.mem_err_i(mem_err_i)
	);

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	// one operation at a time; registers change only on acknowledged access, except pc, which a return loads from the named register in idle
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			state_q <= ST_IDLE;
			op_q <= OP_CALL;
			idx_q <= 3'h0;
			tgt_q <= 16'h0000;
			ra_q <= 16'h0000;
			psw_save_q <= 16'h0000;
			psw_q <= sslk_pkg::RESET_PSW;
			byte_q <= 1'b0;
			done_q <= 1'b0;
			fault_q <= 1'b0;
			for (int i = 0; i < 8; i++) begin
				regs_q[i] <= 16'h0000;
			end
		end else begin
			done_q <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					ra_q <= ret_addr_i;
					tgt_q <= target_i;
					psw_save_q <= psw_q;
					if (trap_i) begin
						op_q <= OP_TRAP;
						ra_q <= regs_q[sslk_pkg::PC_IDX];
						tgt_q <= target_i;
						psw_save_q <= psw_in_i;
						state_q <= ST_PUSH1;
					end else if (call_i) begin
						op_q <= OP_CALL;
						idx_q <= link_reg_i;
						state_q <= ST_PUSH1;
					end else if (ret_i) begin
						op_q <= OP_RET;
						idx_q <= link_reg_i;
						regs_q[sslk_pkg::PC_IDX] <= regs_q[link_reg_i]; // [R04]
						state_q <= ST_POP;
					end else if (pop_i) begin
						op_q <= OP_POP;
						idx_q <= pop_reg_i;
						byte_q <= pop_byte_i;
						// refused pops fault before any memory request goes out
						state_q <= (pop_bad || pop_odd_sp) ? ST_FAULT : ST_POP; // [R06] [R09]
					end
				end
				ST_PUSH1: begin
					if (mem.err) begin
						state_q <= ST_FAULT; // [R10]
					end else if (mem.ack) begin
						regs_q[sslk_pkg::SP_IDX] <= sp_dec; // [R01] [R08]
						if (op_q == OP_TRAP) begin
							state_q <= ST_PUSH2; // [R05]
						end else begin
							regs_q[idx_q] <= ra_q; // [R02] [R10]
							regs_q[sslk_pkg::PC_IDX] <= tgt_q; // [R02] [R03]
							state_q <= ST_DONE;
						end
					end
				end
				ST_PUSH2: begin
					if (mem.err) begin
						state_q <= ST_FAULT;
					end else if (mem.ack) begin
						regs_q[sslk_pkg::SP_IDX] <= sp_dec; // [R05]
						regs_q[sslk_pkg::PC_IDX] <= tgt_q;
						state_q <= ST_DONE;
					end
				end
				ST_POP: begin
					if (!byte_ok) begin
						state_q <= ST_FAULT; // [R06]
					end else if (mem.err) begin
						state_q <= ST_FAULT;
					end else if (mem.ack) begin
						if (op_q == OP_RET) begin
							regs_q[sslk_pkg::SP_IDX] <= pop_next; // [R04]
							regs_q[idx_q] <= mem.rdata; // [R04]
						end else begin
							regs_q[idx_q] <= pop_next; // [R07]
							if (idx_q == sslk_pkg::SP_IDX) begin
								regs_q[idx_q] <= pop_next & sslk_pkg::WORD_ALIGN_MASK;
							end
						end
						state_q <= ST_DONE;
					end
				end
				ST_DONE: begin
					done_q <= 1'b1;
					state_q <= ST_IDLE;
				end
				ST_FAULT: begin
					fault_q <= 1'b1;
					state_q <= ST_IDLE;
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
			if (state_q == ST_IDLE) begin
				fault_q <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign busy_o = (state_q != ST_IDLE);
	assign done_o = done_q;
	assign fault_o = fault_q;
	assign pc_o = regs_q[sslk_pkg::PC_IDX];
	assign sp_o = regs_q[sslk_pkg::SP_IDX];
	assign psw_o = psw_q;
	assign rd_data_o = regs_q[rd_idx_i];

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_push_aligned: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R06]
		(mem.req && mem.we) |-> (mem_addr_o[0] == 1'b0))
		else $error("stack push at odd address");
	a_push_predec: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R01]
		(in_push && mem.ack && !mem.err) |=> (sp_o == $past(sp_dec)))
		else $error("stack pointer not predecremented");
	a_call_link: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R02]
		(state_q == ST_PUSH1 && op_q == OP_CALL && mem.ack && !mem.err)
		|=> (pc_o == $past(tgt_q)))
		else $error("call did not load entry address");
	a_call_pc_word: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R03]
		(state_q == ST_PUSH1 && op_q == OP_CALL && idx_q == sslk_pkg::PC_IDX)
		|-> (mem.wdata == ra_q))
		else $error("pc call pushed wrong word");
	a_ret_pop: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R04]
		(in_pop && op_q == OP_RET && mem.ack && !mem.err)
		|=> (sp_o == $past(sp_cur) + 16'h0002))
		else $error("return did not pop one word");
	a_trap_two: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R05]
		(state_q == ST_PUSH1 && op_q == OP_TRAP && mem.ack && !mem.err)
		|=> (state_q == ST_PUSH2 && mem_we_o && mem_wdata_o == psw_save_q
		&& mem_addr_o == $past(mem_addr_o) - 16'h0002))
		else $error("trap did not push status word");
	a_fault_hold: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R10]
		(in_push && mem.err) |=> ($stable(pc_o) && $stable(sp_o)))
		else $error("faulting push changed state");
	a_sp_even: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R08]
		$past(sp_o[0] == 1'b0) && op_q != OP_POP |-> (sp_o[0] == 1'b0))
		else $error("stack pointer went odd");
endmodule
`default_nettype wire

// file: testbench/sslk_mem_model.sv
// Purpose: stack memory partner with a settable answer delay
// Assumes: one word request held until answered
// Notes: read data changes every cycle outside an answer
`timescale 1ns/100ps
`default_nettype none
module sslk_mem_model (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// memory pins
	input wire logic req_i,
	input wire logic we_i,
	input wire logic [15:0] addr_i,
	input wire logic [15:0] wdata_i,
	output logic [15:0] rdata_o,
	output logic ack_o,
	output logic err_o,
	// behaviour control
	input wire logic [3:0] lat_i,
	input wire logic fail_i
);
	logic [15:0] mem [256];
	logic [3:0] cnt_q;
	// answer after lat_i wait cycles, one cycle pulse
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_q <= 4'h0;
			ack_o <= 1'b0;
			err_o <= 1'b0;
			rdata_o <= 16'h0000;
		end else if (ack_o || err_o) begin
			ack_o <= 1'b0;
			err_o <= 1'b0;
			cnt_q <= 4'h0;
			rdata_o <= ~rdata_o;
		end else if (req_i && cnt_q == lat_i) begin
			ack_o <= !fail_i;
			err_o <= fail_i;
			if (we_i && !fail_i) mem[addr_i[8:1]] <= wdata_i;
			rdata_o <= fail_i ? ~rdata_o : mem[addr_i[8:1]];
		end else begin
			cnt_q <= req_i ? cnt_q + 4'h1 : 4'h0;
			rdata_o <= ~rdata_o;
		end
	end
endmodule
`default_nettype wire

// file: testbench/sslk_test.sv
// Purpose: self-checking bench for call, return, trap and pop linkage
// Assumes: stack pointer starts at zero, so pushes land at the top words
// Notes: memory delay and error answers set per scenario
`timescale 1ns/100ps
`default_nettype none
module sslk_test;
	logic clk_sys_i, rst_i, call_i, ret_i, trap_i, pop_i, pop_byte_i, fail_q;
	logic [2:0] link_reg_i, pop_reg_i, rd_idx_i;
	logic [15:0] target_i, ret_addr_i, psw_in_i, pc_o, sp_o, psw_o, rd_data_o;
	logic busy_o, done_o, fault_o, mem_req_o, mem_we_o, mem_ack_i, mem_err_i;
	logic [15:0] mem_addr_o, mem_wdata_o, mem_rdata_i;
	logic [3:0] lat_q;
	logic got_done, got_fault;
	int n_errors, checked, cyc;
	sslk_top dut_u (.clk_sys_i, .rst_i, .call_i, .ret_i, .trap_i, .pop_i, .pop_byte_i,
		.link_reg_i, .pop_reg_i, .target_i, .ret_addr_i, .psw_in_i, .busy_o, .done_o,
		.fault_o, .pc_o, .sp_o, .psw_o, .rd_idx_i, .rd_data_o, .mem_req_o, .mem_we_o,
		.mem_addr_o, .mem_wdata_o, .mem_rdata_i, .mem_ack_i, .mem_err_i);
	sslk_mem_model mem_u (.clk_sys_i, .rst_i, .req_i(mem_req_o), .we_i(mem_we_o),
		.addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i),
		.ack_o(mem_ack_i), .err_o(mem_err_i), .lat_i(lat_q), .fail_i(fail_q));
	// clock and cycle ceiling
	initial begin
		clk_sys_i = 1'b0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			summarize();
		end
	end
	task automatic summarize();
		$display("checks %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk16(string what, logic [15:0] exp, logic [15:0] got);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk1(string what, logic exp, logic got);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %s expected %b seen %b", what, exp, got);
		end
	endtask
	// pulse one request, then wait for done or fault
	task automatic run(logic [3:0] kind);
		logic [15:0] pc0;
		pc0 = pc_o;
		got_done = 1'b0;
		got_fault = 1'b0;
		@(posedge clk_sys_i);
		{trap_i, call_i, ret_i, pop_i} <= kind;
		@(posedge clk_sys_i);
		{trap_i, call_i, ret_i, pop_i} <= 4'h0;
		for (int i = 0; i < 40 && !got_done && !got_fault; i++) begin
			#1;
			if (mem_req_o === 1'b1 && mem_we_o === 1'b1) chk16("pc in push", pc0, pc_o);
			chk1("sp bit0", 1'b0, sp_o[0]);
			got_done = (done_o === 1'b1);
			got_fault = (fault_o === 1'b1);
			chk1("busy", !(got_done || got_fault), busy_o);
			if (!got_done && !got_fault) @(posedge clk_sys_i);
		end
		@(posedge clk_sys_i);
		#1;
	endtask
	task automatic call_t(logic [2:0] r, logic [15:0] ra, logic [15:0] tg, logic [15:0] sp);
		@(posedge clk_sys_i);
		link_reg_i <= r;
		rd_idx_i <= r;
		ret_addr_i <= ra;
		target_i <= tg;
		run(4'h4);
		chk1("call done", 1'b1, got_done);
		chk16("sp", sp, sp_o);
		chk16("pushed", (r == 3'h7) ? ra : 16'h0000, mem_u.mem[sp[8:1]]);
		chk16("pc", tg, pc_o);
		chk16("link reg", (r == 3'h7) ? tg : ra, rd_data_o);
		$display("call test finished");
	endtask
	task automatic ret_t(logic [2:0] r, logic [15:0] pc, logic [15:0] val, logic [15:0] sp);
		@(posedge clk_sys_i);
		link_reg_i <= r;
		rd_idx_i <= r;
		run(4'h2);
		chk1("return done", 1'b1, got_done);
		chk16("pc", pc, pc_o);
		chk16("popped reg", val, rd_data_o);
		chk16("sp", sp, sp_o);
		$display("return test finished");
	endtask
	task automatic pop_t(logic [2:0] r, logic b, logic flt, logic [15:0] val);
		@(posedge clk_sys_i);
		pop_reg_i <= r;
		pop_byte_i <= b;
		rd_idx_i <= r;
		run(4'h1);
		chk1("fault", flt, got_fault);
		chk1("pop done", !flt, got_done);
		chk16("pointer", val, rd_data_o);
		$display("pop test finished");
	endtask
	task automatic trap_t();
		@(posedge clk_sys_i);
		psw_in_i <= 16'hA5A5;
		target_i <= 16'h0400;
		run(4'h8);
		chk1("trap done", 1'b1, got_done);
		chk16("stacked pc", 16'h1234, mem_u.mem[8'hFF]);
		chk16("stacked status", 16'hA5A5, mem_u.mem[8'hFE]);
		chk16("sp", 16'hFFFC, sp_o);
		chk16("pc", 16'h0400, pc_o);
		chk16("status", sslk_pkg::RESET_PSW, psw_o);
		$display("trap test finished");
	endtask
	task automatic err_t();
		@(posedge clk_sys_i);
		fail_q <= 1'b1;
		link_reg_i <= 3'h2;
		run(4'h4);
		chk1("fault", 1'b1, got_fault);
		chk16("sp kept", 16'hFFFE, sp_o);
		chk16("pc kept", 16'h0400, pc_o);
		@(posedge clk_sys_i);
		fail_q <= 1'b0;
		$display("error test finished");
	endtask
	// main sequence
	initial begin
		{rst_i, call_i, ret_i, trap_i, pop_i, pop_byte_i, fail_q} = 7'h40;
		{link_reg_i, pop_reg_i, rd_idx_i} = 9'h000;
		{target_i, ret_addr_i, psw_in_i} = 48'h0;
		lat_q = 4'h3;
		repeat (2) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		call_t(3'h5, 16'h1234, 16'h0100, 16'hFFFE);
		lat_q <= 4'h0;
		call_t(3'h7, 16'h2222, 16'h0300, 16'hFFFC);
		ret_t(3'h7, 16'h2222, 16'h2222, 16'hFFFE);
		ret_t(3'h5, 16'h1234, 16'h0000, 16'h0000);
		trap_t();
		pop_t(3'h6, 1'b0, 1'b0, 16'hFFFE);
		pop_t(3'h3, 1'b1, 1'b0, 16'h0001);
		pop_t(3'h3, 1'b0, 1'b0, 16'h0003);
		pop_t(3'h6, 1'b1, 1'b1, 16'hFFFE);
		pop_t(3'h7, 1'b0, 1'b1, 16'h0400);
		err_t();
		summarize();
	end
endmodule
`default_nettype wire
